// file: src/link_frame_address_framer.sv
// Address field parser, header queue encoder and concatenation scheduler
`timescale 1ns/100ps
module link_frame_address_framer (
   input  wire logic                       clk_i,
   input  wire logic                       sys_rst_i,
   input  wire link_frame_pkg::link_cfg_t  cfg_i,
   input  wire link_frame_pkg::octet_t     rx_octet_i,
   input  wire logic [6:0]                 own_addr_i,
   input  wire logic [31:0]                own_addr32_i,
   input  wire logic [5:0]                 first_subscriber_i,
   input  wire logic [1:0]                 link_prec_i,
   input  wire logic                       frame_is_info_i,
   input  wire logic                       sched_expire_i,
   input  wire logic                       conc_sent_i,
   input  wire logic                       hi_prec_frame_i,
   output logic                            addr_done_o,
   output logic                            addr_error_o,
   output logic                            for_me_o,
   output logic                            group_seen_o,
   output logic                            response_o,
   output logic [6:0]                      source_addr_o,
   output logic [4:0]                      dest_count_o,
   output logic                            frame_reject_o,
   output logic [9:0]                      queue_field_o,
   output logic                            fsn_error_o,
   output logic                            access_ok_o,
   output logic                            op_allowed_o,
   output logic                            resend_req_o,
   output logic                            build_req_o,
   output logic                            rebuild_req_o
);
   // -----------------------------------------
   // Address classification
   // -----------------------------------------
   function automatic link_frame_pkg::addr_kind_t kind_of(input logic [6:0] a);
      if (a >= link_frame_pkg::INDIV_LOW && a <= link_frame_pkg::INDIV_HIGH)
         kind_of = link_frame_pkg::ADDR_INDIV;
      else if (a >= link_frame_pkg::GROUP_LOW && a <= link_frame_pkg::GROUP_HIGH)
         kind_of = link_frame_pkg::ADDR_GROUP;
      else if (a == 7'h00)
         kind_of = link_frame_pkg::ADDR_RESERVED;
      // Values 1 to 3 are special and share ADDR_OTHER with global;
      // they never match this station on their own.
      else
         kind_of = link_frame_pkg::ADDR_OTHER;
   endfunction

   function automatic logic supports(input link_frame_pkg::station_class_t c,
                                     input link_frame_pkg::op_type_t o);
      unique case (o)
         link_frame_pkg::OP_UNACK,
         link_frame_pkg::OP_ACK:       supports = 1'b1;
         link_frame_pkg::OP_CONN:      supports = (c == link_frame_pkg::CLASS_B) ||
                                                  (c == link_frame_pkg::CLASS_D);
         link_frame_pkg::OP_DECOUPLED: supports = (c == link_frame_pkg::CLASS_C) ||
                                                  (c == link_frame_pkg::CLASS_D);
      endcase
   endfunction

   // -----------------------------------------
   // Input synchronisation
   // -----------------------------------------
   // Octet stream and pins come from the radio side, so two stages each.
   // Config, own addresses and queue inputs come from logic on this
   // clock, so they are read directly.
   link_frame_pkg::octet_t octet_s1, octet;
   logic [2:0] pin_s1, pin_s2;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         octet_s1 <= '0;
         octet    <= '0;
         pin_s1   <= 3'h0;
         pin_s2   <= 3'h0;
      end else begin
         octet_s1 <= rx_octet_i;
         octet    <= octet_s1;
         pin_s1   <= {sched_expire_i, conc_sent_i, hi_prec_frame_i};
         pin_s2   <= pin_s1;
      end
   end
   logic expire, sent, hi_prec;
   assign {expire, sent, hi_prec} = pin_s2;

   // -----------------------------------------
   // Address parser
   // -----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SOURCE = 3'b001,
      ST_SRC4   = 3'b010,
      ST_DEST   = 3'b011,
      ST_DEST4  = 3'b100,
      ST_BODY   = 3'b101
   } parse_state_t;

   parse_state_t state;
   logic [1:0]   byte_idx;
   logic [31:0]  addr_acc;
   logic         last_dest;
   logic [4:0]   next_count;
   logic [6:0]   oval;
   logic         obit;
   assign oval = octet.data[7:1];
   assign obit = octet.data[0];
   assign next_count = dest_count_o + 5'h01;

   // Frame starts on sof after the opening flag; octets handed in are
   // already stripped of flags, so sof marks the source octet.
   // Flag hunting and check sequence live in the bit engine; this
   // block sees every octet between the flags and holds in ST_BODY after the address.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state         <= ST_IDLE;
         byte_idx      <= 2'h0;
         addr_acc      <= 32'h0;
         last_dest     <= 1'b0;
         addr_done_o   <= 1'b0;
         addr_error_o  <= 1'b0;
         for_me_o      <= 1'b0;
         group_seen_o  <= 1'b0;
         response_o    <= 1'b0;
         source_addr_o <= 7'h00;
         dest_count_o  <= 5'h00;
      end else begin
         addr_done_o <= 1'b0;
         if (octet.valid && octet.sof) begin
            for_me_o      <= 1'b0;
            group_seen_o  <= 1'b0;
            addr_error_o  <= 1'b0;
            dest_count_o  <= 5'h00;
            response_o    <= obit;
            source_addr_o <= oval;
            byte_idx      <= 2'h0;
            if (cfg_i.four_octet && oval == link_frame_pkg::MARKER_VALUE)
               state <= ST_SRC4;
            else
               state <= ST_DEST;
         end else if (octet.valid) begin
            unique case (state)
               ST_IDLE, ST_BODY, ST_SOURCE: state <= state;
               ST_SRC4: begin
                  byte_idx <= byte_idx + 2'h1;
                  if (byte_idx == link_frame_pkg::MARK_BYTES)
                     state <= ST_DEST;
               end
               ST_DEST: begin
                  dest_count_o <= next_count;
                  if (cfg_i.four_octet && oval == link_frame_pkg::MARKER_VALUE) begin
                     last_dest <= obit;
                     byte_idx  <= 2'h0;
                     addr_acc  <= 32'h0;
                     state     <= ST_DEST4;
                  end else begin
                     unique case (kind_of(oval))
                        link_frame_pkg::ADDR_INDIV:
                           if (!cfg_i.four_octet && oval == own_addr_i)
                              for_me_o <= 1'b1;
                        link_frame_pkg::ADDR_GROUP:
                           group_seen_o <= cfg_i.group_en;
                        // Reserved zero is skipped yet still counts toward sixteen
                        link_frame_pkg::ADDR_RESERVED: for_me_o <= for_me_o;
                        link_frame_pkg::ADDR_OTHER:
                           if (oval == link_frame_pkg::GLOBAL_VALUE)
                              for_me_o <= 1'b1;
                     endcase
                     if (obit) begin
                        addr_done_o <= 1'b1;
                        state       <= ST_BODY;
                     end else if (next_count == link_frame_pkg::MAX_DEST_CNT) begin
                        addr_error_o <= 1'b1;
                        state        <= ST_BODY;
                     end
                  end
               end
               ST_DEST4: begin
                  byte_idx <= byte_idx + 2'h1;
                  // Octets arrive most significant first, so shift in from the right
                  addr_acc <= {addr_acc[23:0], octet.data};
                  if (byte_idx == link_frame_pkg::MARK_BYTES) begin
                     // Reserved four-octet values are never a station match
                     if ({addr_acc[23:0], octet.data} == own_addr32_i &&
                         own_addr32_i >= link_frame_pkg::FOUR_OCT_MIN)
                        for_me_o <= 1'b1;
                     if (last_dest) begin
                        addr_done_o <= 1'b1;
                        state       <= ST_BODY;
                     end else if (dest_count_o == link_frame_pkg::MAX_DEST_CNT) begin
                        addr_error_o <= 1'b1;
                        state        <= ST_BODY;
                     end else begin
                        state <= ST_DEST;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
         if (octet.valid && octet.eof)
            state <= ST_IDLE;
      end
   end

   // -----------------------------------------
   // Operation checks
   // -----------------------------------------
   // Information frames belong to connection mode only.
   // Classes A and C refuse them; B and D accept.
   // The refusal pulse trails the done pulse by one cycle.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         frame_reject_o <= 1'b0;
         op_allowed_o   <= 1'b0;
         access_ok_o    <= 1'b0;
      end else begin
         frame_reject_o <= addr_done_o && frame_is_info_i &&
                           !supports(cfg_i.st_class, link_frame_pkg::OP_CONN);
         op_allowed_o   <= supports(cfg_i.st_class, link_frame_pkg::OP_DECOUPLED);
         access_ok_o    <= !cfg_i.sync_mode ||
                           cfg_i.access == link_frame_pkg::ACC_RANDOM ||
                           cfg_i.access == link_frame_pkg::ACC_ADAPTIVE;
      end
   end

   // -----------------------------------------
   // Transmission queue field
   // -----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         queue_field_o <= 10'h000;
         fsn_error_o   <= 1'b0;
      end else begin
         // Bit 0 of the code is the subscriber's lowest bit, placed at field bit 4
         // A zero code still lands in the field; the error flag tells the
         // sender to hold the header back rather than send an illegal slot.
         queue_field_o <= {first_subscriber_i, link_prec_i,
                           link_frame_pkg::TBITS_PRIORITY};
         fsn_error_o   <= (first_subscriber_i == 6'h00);
      end
   end

   // -----------------------------------------
   // Concatenation scheduler
   // -----------------------------------------
   // Expiry wins over a same-cycle sent report so no build is lost.
   // A rebuild request repeats each cycle the higher precedence level stays,
   // so the upper layer acts on its first cycle and ignores the rest.
   logic pending;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pending       <= 1'b0;
         resend_req_o  <= 1'b0;
         build_req_o   <= 1'b0;
         rebuild_req_o <= 1'b0;
      end else begin
         resend_req_o  <= 1'b0;
         build_req_o   <= 1'b0;
         rebuild_req_o <= 1'b0;
         if (expire) begin
            if (pending && !sent) begin
               resend_req_o <= 1'b1;
            end else begin
               build_req_o <= 1'b1;
               pending     <= 1'b1;
            end
         end else if (sent) begin
            pending <= 1'b0;
         end
         if (pending && !sent && hi_prec)
            rebuild_req_o <= 1'b1;
      end
   end
endmodule

// file: common/link_frame_pkg.sv
// Package of constants and carriers for the link frame address framer
// How it works
// - Six-bit first subscriber code, lowest bit first; zero code is rejected.
// - Every frame and header opens and closes with flag 01111110.
// - Header: flag, two info octets, 32-bit check, flag; frames follow.
// - Source octet: command/response in bit 0, seven-bit source above it.
// - Destination octet: extension bit 0 continues, 1 ends; address above.
// - Destination list holds one to sixteen addresses, all lengths handled.
// - Single-octet addressing always; four-octet optional; one format per net.
// - Four-octet address is marker 126 then four octets; others single octet.
// - Marker carries command/response at source, extension at destinations.
// - Four-octet list ends at first octet or marker with extension set.
// - On scheduler expiry resend unsent concatenation, else build a new one.
// - Higher precedence frame arriving while unsent forces a rebuild.
// - Synchronous net must offer adaptive priority and random access delay.
// - Information frames only in connection mode; never in other operations.
// - Unacknowledged and acknowledged connectionless operation always supported.
// - Station class A to D selects supported operation types.
// - First subscriber sits in bits 4 to 9 when type bits select priority.
// - Single-octet individual addresses lie in range 4 to 95.
// - Values 96 to 125 recognised as group; ignored if groups unsupported.
package link_frame_pkg;
   localparam logic [7:0] FLAG_OCTET      = 8'h7E;
   localparam logic [6:0] MARKER_VALUE    = 7'h7E;
   localparam logic [6:0] GLOBAL_VALUE    = 7'h7F;
   localparam logic [6:0] INDIV_LOW       = 7'h04;
   localparam logic [6:0] INDIV_HIGH      = 7'h5F;
   localparam logic [6:0] GROUP_LOW       = 7'h60;
   localparam logic [6:0] GROUP_HIGH      = 7'h7D;
   localparam logic [31:0] FOUR_OCT_MIN   = 32'h00000080;
   localparam int          MAX_DEST       = 16;
   localparam logic [4:0]  MAX_DEST_CNT   = 5'h10;
   // Field bit 0 is the first T-bit, so "10" is a one in bit 0
   localparam logic [1:0]  TBITS_PRIORITY = 2'h1;
   localparam int          FSN_POS        = 4;
   localparam logic [1:0]  MARK_BYTES     = 2'h3;

   typedef enum logic [1:0] {
      CLASS_A = 2'b00, CLASS_B = 2'b01, CLASS_C = 2'b10, CLASS_D = 2'b11
   } station_class_t;

   typedef enum logic [1:0] {
      OP_UNACK = 2'b00, OP_CONN = 2'b01, OP_ACK = 2'b10, OP_DECOUPLED = 2'b11
   } op_type_t;

   typedef enum logic [1:0] {
      ACC_RANDOM = 2'b00, ACC_ADAPTIVE = 2'b01, ACC_HYBRID = 2'b10, ACC_PRIO = 2'b11
   } access_mode_t;

   typedef enum logic [1:0] {
      ADDR_RESERVED = 2'b00, ADDR_INDIV = 2'b01, ADDR_GROUP = 2'b10, ADDR_OTHER = 2'b11
   } addr_kind_t;

   typedef struct packed {
      logic       valid;
      logic       sof;
      logic       eof;
      logic [7:0] data;
   } octet_t;

   typedef struct packed {
      logic       four_octet;
      logic       group_en;
      logic       sync_mode;
      station_class_t st_class;
      access_mode_t   access;
   } link_cfg_t;
endpackage

// file: tb/link_frame_address_framer_assertions.sv
// Port-level assertions for the address framer
`timescale 1ns/100ps
module link_frame_address_framer_assertions (
   input wire logic                      clk_i,
   input wire logic                      sys_rst_i,
   input wire link_frame_pkg::link_cfg_t cfg_i,
   input wire logic                      frame_is_info_i,
   input wire logic                      sched_expire_i,
   input wire logic                      hi_prec_frame_i,
   input wire logic                      addr_done_o,
   input wire logic                      addr_error_o,
   input wire logic                      frame_reject_o,
   input wire logic [9:0]                queue_field_o,
   input wire logic                      fsn_error_o,
   input wire logic                      access_ok_o,
   input wire logic                      op_allowed_o,
   input wire logic                      resend_req_o,
   input wire logic                      build_req_o,
   input wire logic                      rebuild_req_o
);
   // ---------------------------------------------
   // Settling counter
   // ---------------------------------------------
   // Level outputs are judged only once reset values have flushed through
   logic [1:0] up_cnt;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         up_cnt <= 2'h0;
      end else if (up_cnt != 2'h3) begin
         up_cnt <= up_cnt + 2'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_tbits_prio: assert property (up_cnt == 2'h3 |-> queue_field_o[1:0] == 2'h1)
      else $error("queue type bits wrong");
   a_fsn_zero: assert property (up_cnt == 2'h3 |-> fsn_error_o == (queue_field_o[9:4] == 6'h00))
      else $error("subscriber code check wrong");
   a_done_pulse: assert property (addr_done_o |=> !addr_done_o)
      else $error("done held too long");
   a_done_err_excl: assert property (!(addr_done_o && addr_error_o))
      else $error("done and error together");
   a_reject_cause: assert property (addr_done_o && frame_is_info_i && !cfg_i.st_class[0] |=> frame_reject_o)
      else $error("info frame not refused");
   a_reject_only: assert property (frame_reject_o |-> $past(addr_done_o))
      else $error("refusal without frame");
   a_access_sel: assert property (up_cnt == 2'h3 |-> access_ok_o == (!$past(cfg_i.sync_mode) || !$past(cfg_i.access[1])))
      else $error("access mode check wrong");
   a_class_decoupled: assert property (up_cnt == 2'h3 |-> op_allowed_o == $past(cfg_i.st_class[1]))
      else $error("class support wrong");
   a_build_cause: assert property (build_req_o |-> $past(sched_expire_i, 3) && !resend_req_o)
      else $error("build without expiry");
   a_rebuild_cause: assert property (rebuild_req_o |-> $past(hi_prec_frame_i, 3))
      else $error("rebuild without cause");
   c_reject: cover property (frame_reject_o);
   c_resend: cover property (resend_req_o);
   c_rebuild: cover property (rebuild_req_o);
   c_error: cover property (addr_error_o);
endmodule

// file: tb/phy_model.sv
// Physical layer stand-in delivering address octets and sent reports
`timescale 1ns/100ps
module phy_model (
   input  wire logic                clk_i,
   output link_frame_pkg::octet_t   rx_octet_o,
   output logic                     conc_sent_o
);
   initial begin
      rx_octet_o = '0;
      conc_sent_o = 1'b0;
   end
   // ---------------------------------------------
   // Frame delivery
   // ---------------------------------------------
   // Flags are already stripped; sof and eof cut the frame instead
   task automatic send(input logic [7:0] q[$], input int gap);
      for (int i = 0; i < q.size(); i++) begin
         repeat (gap) begin
            @(negedge clk_i);
            rx_octet_o.valid = 1'b0;
         end
         @(negedge clk_i);
         rx_octet_o = '{1'b1, i == 0, i == q.size() - 1, q[i]};
      end
      @(negedge clk_i);
      // Idle data inverts so a stale octet never looks held
      rx_octet_o = '{1'b0, 1'b0, 1'b0, ~rx_octet_o.data};
   endtask
   task automatic pulse_sent();
      @(negedge clk_i);
      conc_sent_o = 1'b1;
      @(negedge clk_i);
      conc_sent_o = 1'b0;
   endtask
endmodule

// file: tb/link_frame_address_framer_tb.sv
// Self-checking bench for the address framer
`timescale 1ns/100ps
module link_frame_address_framer_tb;
   logic                      clk_i = 1'b0;
   logic                      sys_rst_i = 1'b1;
   link_frame_pkg::link_cfg_t cfg_i = '0;
   link_frame_pkg::octet_t    rx_octet_i;
   logic [6:0]                own_addr_i = 7'h15;
   logic [31:0]               own_addr32_i = 32'h00012345;
   logic [5:0]                first_subscriber_i = 6'h01;
   logic [1:0]                link_prec_i = 2'h0;
   logic                      frame_is_info_i = 1'b0;
   logic                      sched_expire_i = 1'b0;
   logic                      hi_prec_frame_i = 1'b0;
   logic                      conc_sent_i;
   logic addr_done_o, addr_error_o, for_me_o, group_seen_o, response_o, frame_reject_o;
   logic fsn_error_o, access_ok_o, op_allowed_o, resend_req_o, build_req_o, rebuild_req_o;
   logic [6:0]                source_addr_o;
   logic [4:0]                dest_count_o;
   logic [9:0]                queue_field_o;
   int                        fail_count = 0;
   int                        num_checks = 0;
   logic [7:0]                q[$];
   link_frame_address_framer dut_u (.*);
   phy_model phy_u (.clk_i(clk_i), .rx_octet_o(rx_octet_i), .conc_sent_o(conc_sent_i));
   always #4 clk_i = ~clk_i;
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_addr();
      for (int n = 0; addr_done_o !== 1'b1 && addr_error_o !== 1'b1; n++) begin
         if (n > 60) begin
            fail_count++;
            print_verdict();
         end
         @(negedge clk_i);
      end
   endtask
   task automatic addr_frame(input int n, input logic cr, input int gap);
      logic [6:0] a;
      logic [6:0] src;
      logic       me;
      logic       grp;
      me = 1'b0;
      grp = 1'b0;
      src = 7'($urandom_range(4, 95));
      q = {{src, cr}};
      for (int i = 0; i < n; i++) begin
         a = ($urandom_range(3) == 0) ? own_addr_i : 7'($urandom_range(127));
         if (a == 7'h7E) a = 7'h7F;
         me |= (a == own_addr_i) || (a == 7'h7F);
         grp |= cfg_i.group_en && a >= 7'h60 && a <= 7'h7D;
         q.push_back({a, i == n - 1});
      end
      phy_u.send(q, gap);
      wait_addr();
      check("done", addr_done_o, 1);
      check("count", dest_count_o, n);
      check("for_me", for_me_o, me);
      check("group", group_seen_o, grp);
      check("source", source_addr_o, src);
      check("cr", response_o, cr);
      @(negedge clk_i);
      check("reject", frame_reject_o, frame_is_info_i && !cfg_i.st_class[0]);
   endtask
   task automatic four_frame(input logic me);
      // Source is marker then four octets; group 96 closes the list
      q = {8'hFC, 8'h00, 8'h00, 8'h12, 8'h34, 8'hFC, own_addr32_i[31:24],
           own_addr32_i[23:16], own_addr32_i[15:8], own_addr32_i[7:0], 8'hC1};
      phy_u.send(q, 1);
      wait_addr();
      check("count4", dest_count_o, 2);
      check("for_me4", for_me_o, me);
      check("cr4", response_o, 0);
   endtask
   task automatic sched(input logic ex, input logic hi, input logic [2:0] exp);
      logic [2:0] seen;
      seen = 3'h0;
      sched_expire_i = ex;
      hi_prec_frame_i = hi;
      @(negedge clk_i);
      sched_expire_i = 1'b0;
      hi_prec_frame_i = 1'b0;
      repeat (6) begin
         @(negedge clk_i);
         seen |= {build_req_o, resend_req_o, rebuild_req_o};
      end
      check("sched", seen, exp);
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(47));
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      for (int n = 1; n <= 16; n++) addr_frame(n, n[0], n % 3);
      $display("test list lengths done");
      frame_is_info_i = 1'b1;
      for (int c = 0; c < 4; c++) begin
         cfg_i.st_class = link_frame_pkg::station_class_t'(c);
         cfg_i.group_en = c[0];
         addr_frame(4, 1'b0, 0);
         check("op_allowed", op_allowed_o, c[1]);
      end
      frame_is_info_i = 1'b0;
      $display("test station class done");
      for (int i = 0; i < 12; i++) begin
         first_subscriber_i = (i < 3) ? 6'(i == 2 ? 63 : i) : 6'($urandom);
         link_prec_i = 2'($urandom);
         repeat (4) @(negedge clk_i);
         check("queue", queue_field_o, {first_subscriber_i, link_prec_i, 2'h1});
         check("fsn_err", fsn_error_o, first_subscriber_i == 6'h00);
      end
      $display("test queue field done");
      for (int i = 0; i < 8; i++) begin
         cfg_i.sync_mode = i[2];
         cfg_i.access = link_frame_pkg::access_mode_t'(i[1:0]);
         repeat (2) @(negedge clk_i);
         check("access_ok", access_ok_o, !i[2] || !i[1]);
      end
      $display("test access modes done");
      cfg_i.four_octet = 1'b1;
      four_frame(1'b1);
      own_addr32_i = 32'h00000040;
      four_frame(1'b0);
      cfg_i.four_octet = 1'b0;
      $display("test four octet done");
      sched(1'b1, 1'b0, 3'b100);
      sched(1'b1, 1'b0, 3'b010);
      sched(1'b0, 1'b1, 3'b001);
      phy_u.pulse_sent();
      repeat (4) @(negedge clk_i);
      sched(1'b0, 1'b1, 3'b000);
      sched(1'b1, 1'b0, 3'b100);
      $display("test scheduler done");
      q = {8'h2A};
      repeat (17) q.push_back(8'h28);
      phy_u.send(q, 0);
      wait_addr();
      check("addr_error", addr_error_o, 1);
      $display("test unterminated list done");
      print_verdict();
   end
endmodule
bind link_frame_address_framer link_frame_address_framer_assertions chk_u (.*);
